// ### rtl/iicw_pkg.sv
// ----------------------------------------------------------------------------
// shared constants for the isochronous in byte count write-back
// ----------------------------------------------------------------------------
package iicw_pkg;
   // count and microframe geometry
   localparam int CNT_W = 12;        // width of one received byte count
   localparam int UFRAMES = 8;       // microframes per frame
   localparam int UF_W = 3;          // width of a microframe index
   localparam int FRAME_W = 5;       // width of the compared frame number
   localparam int WORD_W = 32;       // width of one descriptor half word
   localparam int HI_BASE = 32;      // bit 32 is bit 0 of an upper half word

   // frame number position inside descriptor word one
   localparam int DW1_FRAME_LSB = 3; // frame number sits in bits 7 to 3

   // word seven, upper half (documented bit numbers)
   localparam int UF7_LSB = 52;      // microframe 7 in bits 63 to 52
   localparam int UF6_LSB = 40;      // microframe 6 in bits 51 to 40
   localparam int UF5_HI_LSB = 32;   // microframe 5 bits 11 to 4 in bits 39 to 32
   localparam int UF5_HI_W = 8;
   // word six, lower half
   localparam int UF5_LO_LSB = 28;   // microframe 5 bits 3 to 0 in bits 31 to 28
   localparam int UF5_LO_W = 4;
   localparam int UF4_LSB = 16;      // microframe 4 in bits 27 to 16
   localparam int UF3_LSB = 4;       // microframe 3 in bits 15 to 4
   localparam int UF2_HI_LSB = 0;    // microframe 2 bits 11 to 8 in bits 3 to 0
   localparam int UF2_HI_W = 4;
   // word five, upper half
   localparam int UF2_LO_LSB = 56;   // microframe 2 bits 7 to 0 in bits 63 to 56
   localparam int UF2_LO_W = 8;
   localparam int UF1_LSB = 44;      // microframe 1 in bits 55 to 44
   localparam int UF0_LSB = 32;      // microframe 0 in bits 43 to 32

   // reset value of every stored count
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
endpackage

// ### rtl/iicw_uframe_gate.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// microframe gate: frame match first, then the active bit
// ----------------------------------------------------------------------------
module iicw_uframe_gate
   import iicw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   iicw_uframe_if.gate bus
);
   // picks one microframe's active bit
   function automatic logic uf_active(input logic [UFRAMES-1:0] mask, input logic [UF_W-1:0] idx);
      uf_active = mask[idx];
   endfunction

   // ----------------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------------
   wire logic frame_match;           // descriptor frame equals bus frame
   wire logic active_bit;            // mask bit of the offered microframe, forced low on a frame mismatch
   wire logic accept;                // count may be written back
   assign frame_match = (bus.desc_frame == bus.bus_frame);
   // the active bit is only looked at once the frame is known to match
   assign active_bit = frame_match && uf_active(bus.active_mask, bus.req_uframe);
   assign accept = bus.req_valid && active_bit;

   // registered verdict, so the core sees flop outputs only
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bus.hit_valid <= 1'b0;
         bus.hit_uframe <= '0;
         bus.hit_count <= CNT_RESET;
         bus.miss <= 1'b0;
      end else begin
         bus.hit_valid <= accept;
         bus.hit_uframe <= bus.req_uframe;
         bus.hit_count <= bus.req_count;
         bus.miss <= bus.req_valid && !accept;
      end
   end

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   a_gate_frame_first: assert property (@(posedge ref_clk) disable iff (reset)
      bus.hit_valid |-> $past(bus.desc_frame == bus.bus_frame)
         && $past(uf_active(bus.active_mask, bus.req_uframe)))
      else $error("count accepted without frame match and active bit");
   a_gate_miss_drop: assert property (@(posedge ref_clk) disable iff (reset)
      bus.req_valid && (bus.desc_frame != bus.bus_frame) |=> bus.miss && !bus.hit_valid)
      else $error("count not dropped on frame mismatch");
endmodule
`default_nettype wire

// ### rtl/iicw_uframe_if.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// carrier between the write-back core and its microframe gate
// ----------------------------------------------------------------------------
interface iicw_uframe_if;
   import iicw_pkg::*;
   logic req_valid;                  // one received count offered
   logic [UF_W-1:0] req_uframe;      // microframe it belongs to
   logic [CNT_W-1:0] req_count;      // bytes received
   logic [FRAME_W-1:0] desc_frame;   // frame number held in the descriptor
   logic [FRAME_W-1:0] bus_frame;    // current bus frame number
   logic [UFRAMES-1:0] active_mask;  // microframe active mask
   logic hit_valid;                  // count accepted for write-back
   logic [UF_W-1:0] hit_uframe;      // microframe of the accepted count
   logic [CNT_W-1:0] hit_count;      // accepted count
   logic miss;                       // count dropped by the gate
   modport gate (
      input req_valid, req_uframe, req_count, desc_frame, bus_frame, active_mask,
      output hit_valid, hit_uframe, hit_count, miss
   );
   modport core (
      output req_valid, req_uframe, req_count, desc_frame, bus_frame, active_mask,
      input hit_valid, hit_uframe, hit_count, miss
   );
endinterface
`default_nettype wire

// ### rtl/iicw_writeback.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// isochronous in byte count write-back into descriptor words five to seven
// ----------------------------------------------------------------------------
// Overview of operation
// - record count only if active and frame matches
// - microframe 7 count to word 7 bits 63:52
// - microframe 6 count to word 7 bits 51:40
// - microframe 5 split: 7[39:32], 6[31:28]
// - microframe 4 count to word 6 bits 27:16
// - microframe 3 count to word 6 bits 15:4
// - microframe 2 split: 6[3:0], 5[63:56]
// - microframe 1 count to word 5 bits 55:44
// - microframe 0 count to word 5 bits 43:32
// - compare frame number, then check active bit
module iicw_writeback
   import iicw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic desc_load,                          // new descriptor: counts start at zero
   input wire logic [iicw_pkg::WORD_W-1:0] desc_dw1,    // descriptor word one
   input wire logic [iicw_pkg::UFRAMES-1:0] microframe_active_mask,
   input wire logic [iicw_pkg::FRAME_W-1:0] bus_frame_number,
   input wire logic rx_done,                            // one-cycle pulse: a microframe's data ended
   input wire logic [iicw_pkg::UF_W-1:0] rx_uframe,     // microframe of that data
   input wire logic [iicw_pkg::CNT_W-1:0] rx_byte_count,
   output logic [iicw_pkg::WORD_W-1:0] desc_dw5_hi,     // word five, bits 63 to 32
   output logic [iicw_pkg::WORD_W-1:0] desc_dw6_lo,     // word six, bits 31 to 0
   output logic [iicw_pkg::WORD_W-1:0] desc_dw7_hi,     // word seven, bits 63 to 32
   output logic [iicw_pkg::UFRAMES-1:0] written_mask,   // microframes recorded since load
   output logic count_written,                          // pulse: one count stored
   output logic count_dropped                           // pulse: one count discarded
);
   import iicw_pkg::*;

   // ----------------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------------
   logic [CNT_W-1:0] count_mem [UFRAMES];  // one stored count per microframe
   logic [UFRAMES-1:0] next_written_mask;  // written mask after this cycle
   iicw_uframe_if link ();                 // carrier to the gate

   // ----------------------------------------------------------------------------
   // requests toward the gate
   // ----------------------------------------------------------------------------
   assign link.req_valid = rx_done;
   assign link.req_uframe = rx_uframe;
   assign link.req_count = rx_byte_count;
   // frame number field of word one
   assign link.desc_frame = desc_dw1[DW1_FRAME_LSB +: FRAME_W];
   assign link.bus_frame = bus_frame_number;
   assign link.active_mask = microframe_active_mask;

   // gate decides whether a count may land in the descriptor
   iicw_uframe_gate u_gate (
      .ref_clk(ref_clk),
      .reset(reset),
      .bus(link.gate)
   );

   // ----------------------------------------------------------------------------
   // count store
   // ----------------------------------------------------------------------------
   // on a hit only the addressed slot moves; every other slot holds its count
   always_ff @(posedge ref_clk) begin
      if (reset || desc_load) begin
         for (int i = 0; i < UFRAMES; i++) begin
            count_mem[i] <= CNT_RESET;
         end
      end else if (link.hit_valid) begin
         count_mem[link.hit_uframe] <= link.hit_count;
      end
   end

   // a dropped count writes nothing, so its field simply keeps its value
   assign next_written_mask = written_mask | (link.hit_valid ? (UFRAMES'(1) << link.hit_uframe) : '0);

   // status flags; a load in the same cycle as a hit clears, since the hit
   // belonged to the descriptor being replaced
   always_ff @(posedge ref_clk) begin
      if (reset || desc_load) begin
         written_mask <= '0;
         count_written <= 1'b0;
         count_dropped <= 1'b0;
      end else begin
         written_mask <= next_written_mask;
         count_written <= link.hit_valid;
         count_dropped <= link.miss;
      end
   end

   // ----------------------------------------------------------------------------
   // descriptor word images
   // ----------------------------------------------------------------------------
   // word seven, upper half
   assign desc_dw7_hi[UF7_LSB-HI_BASE +: CNT_W] = count_mem[7];
   assign desc_dw7_hi[UF6_LSB-HI_BASE +: CNT_W] = count_mem[6];
   // microframe 5 straddles the word boundary: high part here
   assign desc_dw7_hi[UF5_HI_LSB-HI_BASE +: UF5_HI_W] = count_mem[5][CNT_W-1 -: UF5_HI_W];
   // word six, lower half
   assign desc_dw6_lo[UF5_LO_LSB +: UF5_LO_W] = count_mem[5][UF5_LO_W-1:0];
   assign desc_dw6_lo[UF4_LSB +: CNT_W] = count_mem[4];
   assign desc_dw6_lo[UF3_LSB +: CNT_W] = count_mem[3];
   // microframe 2 also straddles: its top nibble sits at the bottom of word six
   assign desc_dw6_lo[UF2_HI_LSB +: UF2_HI_W] = count_mem[2][CNT_W-1 -: UF2_HI_W];
   // word five, upper half
   assign desc_dw5_hi[UF2_LO_LSB-HI_BASE +: UF2_LO_W] = count_mem[2][UF2_LO_W-1:0];
   assign desc_dw5_hi[UF1_LSB-HI_BASE +: CNT_W] = count_mem[1];
   assign desc_dw5_hi[UF0_LSB-HI_BASE +: CNT_W] = count_mem[0];

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   a_uf7_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h7 |=> desc_dw7_hi[31:20] == $past(link.hit_count))
      else $error("microframe 7 count not in word 7 bits 63:52");
   a_uf6_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h6 |=> desc_dw7_hi[19:8] == $past(link.hit_count))
      else $error("microframe 6 count not in word 7 bits 51:40");
   a_uf5_split_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h5 |=> {desc_dw7_hi[7:0], desc_dw6_lo[31:28]}
         == $past(link.hit_count))
      else $error("microframe 5 count not split across words 7 and 6");
   a_uf4_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h4 |=> desc_dw6_lo[27:16] == $past(link.hit_count))
      else $error("microframe 4 count not in word 6 bits 27:16");
   a_uf3_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h3 |=> desc_dw6_lo[15:4] == $past(link.hit_count))
      else $error("microframe 3 count not in word 6 bits 15:4");
   a_uf2_split_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h2 |=> {desc_dw6_lo[3:0], desc_dw5_hi[31:24]}
         == $past(link.hit_count))
      else $error("microframe 2 count not split across words 6 and 5");
   a_uf1_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h1 |=> desc_dw5_hi[23:12] == $past(link.hit_count))
      else $error("microframe 1 count not in word 5 bits 55:44");
   a_uf0_field_write: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      link.hit_valid && link.hit_uframe == 3'h0 |=> desc_dw5_hi[11:0] == $past(link.hit_count))
      else $error("microframe 0 count not in word 5 bits 43:32");
   // end to end: a pulse on a matching, active microframe shows up two edges later
   a_record_on_hit: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      rx_done && (desc_dw1[7:3] == bus_frame_number) && microframe_active_mask[rx_uframe]
      |=> ##1 count_written && written_mask[$past(rx_uframe, 2)])
      else $error("matching active count not recorded");
   a_hold_on_miss: assert property (@(posedge ref_clk) disable iff (reset || desc_load)
      !link.hit_valid |=> $stable(desc_dw5_hi) && $stable(desc_dw6_lo) && $stable(desc_dw7_hi))
      else $error("descriptor words changed without an accepted count");
endmodule
`default_nettype wire

// ### sim/iicw_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// far side: a device answering isochronous in tokens, one count per microframe
// ----------------------------------------------------------------------------
module iicw_dev_model
   import iicw_pkg::*;
(
   input wire logic ref_clk,
   output logic rx_done,                              // one-cycle end of data
   output logic [iicw_pkg::UF_W-1:0] rx_uframe,       // microframe of the data
   output logic [iicw_pkg::CNT_W-1:0] rx_byte_count   // bytes received
);
   initial begin
      rx_done = 1'b0;
      rx_uframe = 3'h0;
      rx_byte_count = 12'h000;
   end
   // offer one count; calls may follow each other to give back-to-back pulses
   task automatic send(input logic [iicw_pkg::UF_W-1:0] uf, input logic [iicw_pkg::CNT_W-1:0] cnt);
      @(negedge ref_clk);
      rx_done = 1'b1;
      rx_uframe = uf;
      rx_byte_count = cnt;
   endtask
   // end the pulse; qualifiers turn to the inverse so stale values are never mistaken for fresh
   task automatic idle();
      @(negedge ref_clk);
      rx_done = 1'b0;
      rx_uframe = ~rx_uframe;
      rx_byte_count = ~rx_byte_count;
   endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// self-checking bench for the byte count write-back
// ----------------------------------------------------------------------------
module tb;
   import iicw_pkg::*;
   typedef struct packed {logic [UF_W-1:0] uf; logic [CNT_W-1:0] cnt; logic fm; logic act;} iicw_row_t;
   localparam logic [31:0] DW1 = 32'hffffffaf; // frame 5'h15, spare bits set to catch a wrong slice
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic desc_load = 1'b0;
   logic [WORD_W-1:0] desc_dw1 = DW1;
   logic [UFRAMES-1:0] mask = 8'h00;
   logic [FRAME_W-1:0] bus_frame = 5'h15;
   wire logic rx_done;
   wire logic [UF_W-1:0] rx_uframe;
   wire logic [CNT_W-1:0] rx_byte_count;
   wire logic [WORD_W-1:0] dw5, dw6, dw7;
   wire logic [UFRAMES-1:0] wmask;
   wire logic cw, cd;
   logic [3*WORD_W-1:0] exp_words = '0; // microframe n at bit 12*n of {dw7,dw6,dw5}
   logic [UFRAMES-1:0] exp_mask = 8'h00;
   int n_mismatch = 0;
   int cmp_count = 0;
   // ordinary cases: microframe, count, frame equal, active bit
   iicw_row_t rows [10] = '{'{3'h7, 12'h123, 1'b1, 1'b1}, '{3'h6, 12'hfed, 1'b1, 1'b1},
      '{3'h5, 12'hab9, 1'b1, 1'b1}, '{3'h4, 12'h801, 1'b1, 1'b1}, '{3'h3, 12'h3c6, 1'b1, 1'b1},
      '{3'h2, 12'h7e4, 1'b1, 1'b1}, '{3'h1, 12'hfff, 1'b1, 1'b1}, '{3'h0, 12'h001, 1'b1, 1'b1},
      '{3'h4, 12'h555, 1'b1, 1'b0}, '{3'h2, 12'haaa, 1'b0, 1'b1}};
   always #10 ref_clk = ~ref_clk;
   iicw_dev_model dev (.ref_clk(ref_clk), .rx_done(rx_done), .rx_uframe(rx_uframe), .rx_byte_count(rx_byte_count));
   iicw_writeback DUT (.ref_clk(ref_clk), .reset(reset), .desc_load(desc_load), .desc_dw1(desc_dw1),
      .microframe_active_mask(mask), .bus_frame_number(bus_frame), .rx_done(rx_done),
      .rx_uframe(rx_uframe), .rx_byte_count(rx_byte_count), .desc_dw5_hi(dw5), .desc_dw6_lo(dw6),
      .desc_dw7_hi(dw7), .written_mask(wmask), .count_written(cw), .count_dropped(cd));
   // one comparison: counted, and reported at once on a mismatch
   task automatic chk(input string name, input logic [95:0] e, input logic [95:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", name, e, g);
         n_mismatch++;
      end
   endtask
   // words and sticky mask against the expectation
   task automatic chk_all();
      chk("words", exp_words, {dw7, dw6, dw5});
      chk("written_mask", {88'h0, exp_mask}, {88'h0, wmask});
   endtask
   // verdict and the only end of the run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 200 cycles
   initial begin
      #(20 * 3000);
      n_mismatch++;
      end_of_test();
   end
   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk_all();
      // table: each row offered alone, result seen one edge after the gate takes it
      foreach (rows[i]) begin
         bus_frame = rows[i].fm ? 5'h15 : 5'h14; // off by one: must not match
         mask = rows[i].act ? (8'h01 << rows[i].uf) : ~(8'h01 << rows[i].uf);
         dev.send(rows[i].uf, rows[i].cnt);
         dev.idle();
         @(negedge ref_clk);
         if (rows[i].fm && rows[i].act) begin
            exp_words[12*rows[i].uf +: 12] = rows[i].cnt;
            exp_mask[rows[i].uf] = 1'b1;
         end
         chk("count_written", {95'h0, rows[i].fm & rows[i].act}, {95'h0, cw});
         chk("count_dropped", {95'h0, ~(rows[i].fm & rows[i].act)}, {95'h0, cd});
         chk_all();
      end
      // back to back, same microframe twice: the later count stands
      mask = 8'hff;
      bus_frame = 5'h15;
      dev.send(3'h3, 12'h111);
      dev.send(3'h3, 12'h222);
      dev.send(3'h5, 12'h0f0);
      dev.idle();
      repeat (2) @(negedge ref_clk);
      exp_words[36 +: 12] = 12'h222;
      exp_words[60 +: 12] = 12'h0f0;
      chk_all();
      // new descriptor while a count is in flight: that count is lost
      dev.send(3'h1, 12'h999);
      dev.idle();
      // load meets the gate's verdict on one edge, so the stale count never lands
      desc_load = 1'b1;
      @(negedge ref_clk);
      desc_load = 1'b0;
      chk("count_written", 96'h0, {95'h0, cw});
      repeat (2) @(negedge ref_clk);
      exp_words = '0;
      exp_mask = 8'h00;
      chk_all();
      // second reset in mid-run clears a stored count
      dev.send(3'h7, 12'h321);
      dev.idle();
      @(negedge ref_clk);
      exp_words[84 +: 12] = 12'h321;
      exp_mask[7] = 1'b1;
      chk_all();
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      exp_words = '0;
      exp_mask = 8'h00;
      chk_all();
      end_of_test();
   end
endmodule
`default_nettype wire
